/* File: hdl/serial_port_pkg.sv */
// constants, types and shared helpers of the asynchronous serial port
package serial_port_pkg;
  localparam int unsigned MCLK_HZ = 10_000_000;
  localparam int unsigned REF_CLK_HZ = 20_000_000;
  localparam int unsigned BAUD_MIN_BPS = 300;
  localparam int unsigned BAUD_MAX_BPS = 1_250_000;
  localparam int AXI_ADDR_W = 32;
  localparam int AXI_DATA_W = 32;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPT = 8'h04;
  localparam logic [7:0] ADDR_CLKSEL = 8'h08;
  localparam logic [7:0] ADDR_DIV = 8'h0C;
  localparam logic [7:0] ADDR_ERR = 8'h10;
  localparam logic [7:0] ADDR_RXD = 8'h14;
  localparam logic [7:0] ADDR_TXD = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADDR_FLAGS = 8'h24;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_MSB = 2;
  localparam int CTRL_PAR = 3;
  localparam int CTRL_CHAR8 = 5;
  localparam int CTRL_STOP2 = 6;
  localparam int OPT_TX_INV = 0;
  localparam int OPT_RX_INV = 1;
  localparam int ERR_PAR = 0;
  localparam int ERR_FRM = 1;
  localparam int ERR_OVR = 2;
  localparam int IRQ_RXDONE = 0;
  localparam int IRQ_TXFREE = 1;
  localparam int IRQ_RXERR = 2;
  localparam logic [7:0] CTRL_RST = 8'h20;
  localparam logic [1:0] OPT_RST = 2'h0;
  localparam logic [3:0] CLKSEL_RST = 4'h0;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h20;
  localparam logic [DIV_W-1:0] DIV_MIN = 8'h02;
  localparam int FRAME_W = 12;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ZERO = 2'h1, PAR_ODD = 2'h2,
                            PAR_EVEN = 2'h3} parity_t;

  // wire order <-> value order; 7-bit values get a zero top bit
  function automatic logic [7:0] order_bits(input logic [7:0] d, input logic char8,
                                            input logic msb);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[i] = msb ? d[7-i] : d[i];
    if (!char8) r = msb ? {1'b0, r[7:1]} : {1'b0, r[6:0]};
    return r;
  endfunction : order_bits

  function automatic logic parity_bit(input logic [7:0] v, input parity_t mode);
    return (mode == PAR_EVEN) ? ^v : ((mode == PAR_ODD) ? ~^v : 1'b0);
  endfunction : parity_bit
endpackage : serial_port_pkg

/* File: hdl/ser_cfg_if.sv */
// configuration and bit-rate enable shared by transmitter and receiver
`timescale 1ns/10ps
interface ser_cfg_if #(parameter int DIV_W = 8);
  logic base_tick;
  logic char8;
  logic stop2;
  logic msb_first;
  logic rx_en;
  serial_port_pkg::parity_t parity;
  logic [DIV_W-1:0] divisor;
  modport ctrl (output base_tick, char8, stop2, msb_first, rx_en, parity, divisor);
  modport unit (input base_tick, char8, stop2, msb_first, rx_en, parity, divisor);
endinterface : ser_cfg_if

/* File: hdl/serial_tx.sv */
// transmit shift register and frame serialiser
`timescale 1ns/10ps
module serial_tx #(parameter int DIV_W = 8) (
  input wire logic mclk_in,
  input wire logic rst_in,
  ser_cfg_if.unit cfg,
  input wire logic load_in,
  input wire logic [7:0] data_in,
  output logic busy_out,
  output logic line_out
);
  import serial_port_pkg::*;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
  tx_state_t state_r;
  logic [FRAME_W-1:0] shift_r;
  logic [3:0] bits_r;
  logic [DIV_W-1:0] cnt_r;
  wire logic [7:0] ord = order_bits(data_in, cfg.char8, cfg.msb_first);
  wire logic has_par = (cfg.parity != PAR_NONE);
  wire logic par = has_par ? parity_bit(order_bits(data_in, cfg.char8, 1'b0), cfg.parity) : 1'b1;
  wire logic [3:0] nbits = (cfg.char8 ? 4'h9 : 4'h8) + {3'h0, has_par} + (cfg.stop2 ? 4'h2 : 4'h1);
  wire logic [FRAME_W-1:0] frame = cfg.char8 ? {2'b11, par, ord, 1'b0}
                                             : {3'b111, par, ord[6:0], 1'b0};
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= TX_IDLE;
      shift_r <= '1;
      bits_r <= 4'h0;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        TX_IDLE: if (load_in) begin
          shift_r <= frame;
          bits_r <= nbits;
          cnt_r <= cfg.divisor - 1'b1;
          state_r <= TX_SEND;
        end
        TX_SEND: if (cfg.base_tick) begin
          if (cnt_r == '0) begin
            cnt_r <= cfg.divisor - 1'b1;
            shift_r <= {1'b1, shift_r[FRAME_W-1:1]};
            bits_r <= bits_r - 1'b1;
            if (bits_r == 4'h1) state_r <= TX_IDLE;
          end else cnt_r <= cnt_r - 1'b1;
        end
      endcase
    end
  end
  assign busy_out = (state_r == TX_SEND);
  assign line_out = shift_r[0];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  AST_TX_START_BIT: assert property (load_in && !busy_out |=> !line_out && busy_out)
    else $error("start bit not driven low after load");
endmodule : serial_tx

/* File: hdl/serial_rx.sv */
// receive shift register with centre sampling and error checks
`timescale 1ns/10ps
module serial_rx #(parameter int DIV_W = 8) (
  input wire logic mclk_in,
  input wire logic rst_in,
  ser_cfg_if.unit cfg,
  input wire logic line_in,
  output logic done_out,
  output logic [7:0] data_out,
  output logic perr_out,
  output logic ferr_out
);
  import serial_port_pkg::*;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_BITS = 3'b100} rx_state_t;
  rx_state_t state_r;
  logic prev_r;
  logic par_r;
  logic [3:0] idx_r;
  logic [7:0] raw_r;
  logic [DIV_W-1:0] cnt_r;
  wire logic [3:0] ndata = cfg.char8 ? 4'h8 : 4'h7;
  wire logic has_par = (cfg.parity != PAR_NONE);
  wire logic sample = cfg.base_tick && (cnt_r == '0);
  wire logic [7:0] value = order_bits(raw_r, cfg.char8, cfg.msb_first);
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= RX_IDLE;
      prev_r <= 1'b1;
      par_r <= 1'b0;
      idx_r <= 4'h0;
      raw_r <= 8'h00;
      cnt_r <= '0;
      done_out <= 1'b0;
      data_out <= 8'h00;
      perr_out <= 1'b0;
      ferr_out <= 1'b0;
    end else begin
      prev_r <= line_in;
      done_out <= 1'b0;
      if (cfg.base_tick && state_r != RX_IDLE) cnt_r <= sample ? cfg.divisor - 1'b1 : cnt_r - 1'b1;
      if (!cfg.rx_en) state_r <= RX_IDLE;
      else unique case (state_r)
        // falling edge, half bit to centre
        RX_IDLE: if (prev_r && !line_in) begin
          state_r <= RX_START;
          cnt_r <= cfg.divisor >> 1;
        end
        RX_START: if (sample) begin
          state_r <= line_in ? RX_IDLE : RX_BITS;
          idx_r <= 4'h0;
        end
        RX_BITS: if (sample) begin
          idx_r <= idx_r + 1'b1;
          if (idx_r < ndata) raw_r[idx_r[2:0]] <= line_in;
          else if (has_par && idx_r == ndata) par_r <= line_in;
          else begin
            state_r <= RX_IDLE;
            done_out <= 1'b1;
            data_out <= value;
            ferr_out <= !line_in;
            perr_out <= has_par && (par_r != parity_bit(value, cfg.parity));
          end
        end
      endcase
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  AST_RX_SEVEN_BIT_MSB: assert property (done_out && !cfg.char8 |-> !data_out[7])
    else $error("7-bit character with nonzero top bit");
endmodule : serial_rx

/* File: hdl/async_serial_port.sv */
// asynchronous serial port top: register file, buffers, interrupts, pins
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
module async_serial_port #(
  parameter int DIV_W = serial_port_pkg::DIV_W
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [serial_port_pkg::AXI_ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [serial_port_pkg::AXI_DATA_W-1:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [serial_port_pkg::AXI_ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [serial_port_pkg::AXI_DATA_W-1:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire logic serial_rx_line_in,
  output logic serial_tx_line_out,
  output logic rx_error_irq_out,
  output logic rx_done_irq_out,
  output logic tx_free_irq_out,
  output logic irq_out
);
  import serial_port_pkg::*;

  // aligned and inside the map
  function automatic logic reg_known(input logic [AXI_ADDR_W-1:0] a);
    return (a[AXI_ADDR_W-1:8] == '0) && (a[1:0] == 2'h0) && (a[7:0] <= ADDR_FLAGS);
  endfunction : reg_known

  logic [7:0] serial_ctrl_main_r;
  logic [1:0] serial_option_ctrl_r;
  logic [3:0] base_clock_select_r;
  logic [DIV_W-1:0] baud_divisor_ctrl_r;
  logic [2:0] rx_error_status_r;
  logic [7:0] rx_data_reg_r;
  logic [7:0] tx_data_reg_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic tx_full_r;
  logic rx_full_r;
  logic awrdy_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arrdy_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [AXI_DATA_W-1:0] rdata_r;
  logic rx_meta_r;
  logic rx_sync_r;
  logic tx_line_r;
  logic rx_err_irq_r;
  logic rx_done_irq_r;
  logic tx_free_irq_r;
  logic irq_r;
  logic [15:0] pre_cnt_r;
  logic base_tick_r;

  // ---- bit-rate enable
  wire logic [15:0] pre_last = 16'((17'h1 << base_clock_select_r) - 17'h1);
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt_r <= 16'h0000;
      base_tick_r <= 1'b0;
    end else begin
      base_tick_r <= (pre_cnt_r >= pre_last);
      pre_cnt_r <= (pre_cnt_r >= pre_last) ? 16'h0000 : pre_cnt_r + 16'h0001;
    end
  end

  // ---- configuration carried to the shift engines
  ser_cfg_if #(.DIV_W(DIV_W)) cfg ();
  wire logic tx_en = serial_ctrl_main_r[CTRL_TX_EN];
  wire logic rx_en = serial_ctrl_main_r[CTRL_RX_EN];
  assign cfg.base_tick = base_tick_r;
  assign cfg.char8 = serial_ctrl_main_r[CTRL_CHAR8];
  assign cfg.stop2 = serial_ctrl_main_r[CTRL_STOP2];
  assign cfg.msb_first = serial_ctrl_main_r[CTRL_MSB];
  assign cfg.rx_en = rx_en;
  assign cfg.parity = parity_t'(serial_ctrl_main_r[CTRL_PAR+1:CTRL_PAR]);
  assign cfg.divisor = baud_divisor_ctrl_r;

  // ---- receive pin: two flops, then optional inversion
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= serial_rx_line_in;
      rx_sync_r <= rx_meta_r;
    end
  end
  wire logic rx_line = rx_sync_r ^ serial_option_ctrl_r[OPT_RX_INV];

  // ---- shift engines, independent of each other
  logic tx_busy;
  logic tx_line;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_perr;
  logic rx_ferr;
  wire logic tx_load = tx_full_r && !tx_busy && tx_en;
  serial_tx #(.DIV_W(DIV_W)) u_tx (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .cfg(cfg),
    .load_in(tx_load),
    .data_in(tx_data_reg_r),
    .busy_out(tx_busy),
    .line_out(tx_line)
  );
  serial_rx #(.DIV_W(DIV_W)) u_rx (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .cfg(cfg),
    .line_in(rx_line),
    .done_out(rx_done),
    .data_out(rx_data),
    .perr_out(rx_perr),
    .ferr_out(rx_ferr)
  );

  // ---- bus decode
  wire logic aw_go = axi_awvalid_in && axi_wvalid_in && !awrdy_r && !bvalid_r;
  wire logic wr_en = awrdy_r && axi_awvalid_in && axi_wvalid_in;
  wire logic wr_ok = wr_en && reg_known(axi_awaddr_in) && axi_wstrb_in[0];
  wire logic [7:0] wa = axi_awaddr_in[7:0];
  wire logic [7:0] wb = axi_wdata_in[7:0];
  wire logic ar_go = axi_arvalid_in && !arrdy_r && !rvalid_r;
  wire logic rd_en = arrdy_r && axi_arvalid_in;
  wire logic rd_ok = rd_en && reg_known(axi_araddr_in);
  wire logic [7:0] ra = axi_araddr_in[7:0];
  wire logic wr_ctrl = wr_ok && (wa == ADDR_CTRL);
  wire logic wr_opt = wr_ok && (wa == ADDR_OPT);
  wire logic wr_clksel = wr_ok && (wa == ADDR_CLKSEL);
  wire logic wr_div = wr_ok && (wa == ADDR_DIV);
  wire logic wr_err = wr_ok && (wa == ADDR_ERR);
  wire logic wr_txd = wr_ok && (wa == ADDR_TXD);
  wire logic wr_stat = wr_ok && (wa == ADDR_IRQ_STAT);
  wire logic wr_mask = wr_ok && (wa == ADDR_IRQ_MASK);
  wire logic rd_rxd = rd_ok && (ra == ADDR_RXD);
  // a write to a full buffer is dropped unless it leaves this cycle
  wire logic wr_txd_ok = wr_txd && tx_en && (!tx_full_r || tx_load);
  wire logic [DIV_W-1:0] div_wr = (wb[DIV_W-1:0] < DIV_MIN) ? DIV_MIN : wb[DIV_W-1:0];

  // ---- receive transfer and error detection
  wire logic rx_take = rx_done && rx_en;
  wire logic overrun = rx_take && rx_full_r && !rd_rxd;
  wire logic [2:0] err_set = {overrun, rx_take && rx_ferr, rx_take && rx_perr};
  wire logic [2:0] err_clr = wr_err ? wb[2:0] : 3'h0;
  wire logic [2:0] err_nxt = (rx_error_status_r & ~err_clr) | err_set;
  wire logic [2:0] irq_set = {|err_set, tx_load, rx_take};
  wire logic [2:0] irq_clr = wr_stat ? wb[2:0] : 3'h0;
  wire logic [2:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  wire logic [2:0] irq_mask_nxt = wr_mask ? wb[2:0] : irq_mask_r;

  // ---- read data selection
  wire logic [7:0] flags = {5'h00, rx_full_r, tx_busy, tx_full_r};
  wire logic [7:0] rd_byte =
    (ra == ADDR_CTRL) ? serial_ctrl_main_r :
    (ra == ADDR_OPT) ? {6'h00, serial_option_ctrl_r} :
    (ra == ADDR_CLKSEL) ? {4'h0, base_clock_select_r} :
    (ra == ADDR_DIV) ? 8'(baud_divisor_ctrl_r) :
    (ra == ADDR_ERR) ? {5'h00, rx_error_status_r} :
    (ra == ADDR_RXD) ? rx_data_reg_r :
    (ra == ADDR_TXD) ? tx_data_reg_r :
    (ra == ADDR_IRQ_STAT) ? {5'h00, irq_stat_r} :
    (ra == ADDR_IRQ_MASK) ? {5'h00, irq_mask_r} : flags;

  // ---- bus handshakes
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      awrdy_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= AXI_OKAY;
      arrdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= AXI_OKAY;
      rdata_r <= '0;
    end else begin
      awrdy_r <= aw_go;
      arrdy_r <= ar_go;
      if (wr_en) begin
        bvalid_r <= 1'b1;
        bresp_r <= reg_known(axi_awaddr_in) ? AXI_OKAY : AXI_SLVERR;
      end else if (axi_bready_in) bvalid_r <= 1'b0;
      if (rd_en) begin
        rvalid_r <= 1'b1;
        rresp_r <= rd_ok ? AXI_OKAY : AXI_SLVERR;
        rdata_r <= rd_ok ? {24'h000000, rd_byte} : '0;
      end else if (axi_rready_in) rvalid_r <= 1'b0;
    end
  end

  // ---- configuration registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_ctrl_main_r <= CTRL_RST;
      serial_option_ctrl_r <= OPT_RST;
      base_clock_select_r <= CLKSEL_RST;
      baud_divisor_ctrl_r <= DIV_RST;
      irq_mask_r <= 3'h0;
    end else begin
      if (wr_ctrl) serial_ctrl_main_r <= {1'b0, wb[6:0]};
      if (wr_opt) serial_option_ctrl_r <= wb[1:0];
      if (wr_clksel) base_clock_select_r <= wb[3:0];
      if (wr_div) baud_divisor_ctrl_r <= div_wr;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // ---- data buffers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_data_reg_r <= 8'h00;
      tx_full_r <= 1'b0;
      rx_data_reg_r <= 8'h00;
      rx_full_r <= 1'b0;
    end else begin
      if (wr_txd_ok) tx_data_reg_r <= wb;
      tx_full_r <= wr_txd_ok || (tx_full_r && !tx_load);
      if (rx_take) rx_data_reg_r <= rx_data;
      rx_full_r <= rx_take || (rx_full_r && !rd_rxd);
    end
  end

  // ---- status, interrupts and pins
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_error_status_r <= 3'h0;
      irq_stat_r <= 3'h0;
      rx_err_irq_r <= 1'b0;
      rx_done_irq_r <= 1'b0;
      tx_free_irq_r <= 1'b0;
      irq_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else begin
      rx_error_status_r <= err_nxt;
      irq_stat_r <= irq_stat_nxt;
      rx_err_irq_r <= |err_set;
      rx_done_irq_r <= rx_take;
      tx_free_irq_r <= tx_load;
      irq_r <= |(irq_stat_nxt & irq_mask_nxt);
      tx_line_r <= tx_line ^ serial_option_ctrl_r[OPT_TX_INV];
    end
  end

  assign axi_awready_out = awrdy_r;
  assign axi_wready_out = awrdy_r;
  assign axi_bvalid_out = bvalid_r;
  assign axi_bresp_out = bresp_r;
  assign axi_arready_out = arrdy_r;
  assign axi_rvalid_out = rvalid_r;
  assign axi_rresp_out = rresp_r;
  assign axi_rdata_out = rdata_r;
  assign serial_tx_line_out = tx_line_r;
  assign rx_error_irq_out = rx_err_irq_r;
  assign rx_done_irq_out = rx_done_irq_r;
  assign tx_free_irq_out = tx_free_irq_r;
  assign irq_out = irq_r;

  // ---- checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_txd_accept;
    wr_txd_ok && !tx_full_r && !tx_busy;
  endsequence
  sequence s_tx_running;
    ##[1:2] (tx_busy && !tx_full_r);
  endsequence
  sequence s_frame_taken;
    rx_done && rx_en;
  endsequence

  AST_RX_ERR_IRQ: assert property (rx_done && rx_en && (rx_perr || rx_ferr) |=>
    rx_err_irq_r)
    else $error("reception error did not raise its request");
  AST_ERR_FLAG_SET: assert property (|err_set |=>
    (rx_error_status_r & $past(err_set)) == $past(err_set))
    else $error("error flag not set by its error");
  AST_RX_MOVE: assert property (s_frame_taken |=>
    rx_data_reg_r == $past(rx_data) && rx_full_r)
    else $error("received frame not moved into rx data");
  AST_RX_GATED: assert property (rx_done && !rx_en |=>
    !rx_done_irq_r && $stable(rx_data_reg_r))
    else $error("frame moved while reception disabled");
  AST_RX_DONE_IRQ: assert property (s_frame_taken |=>
    rx_done_irq_r ##1 !rx_done_irq_r || rx_done)
    else $error("reception-end request missing");
  AST_TX_START: assert property (s_txd_accept |-> s_tx_running)
    else $error("buffer write did not start transmission");
  AST_TX_FREE: assert property (tx_load |=> tx_free_irq_r && irq_stat_r[IRQ_TXFREE])
    else $error("buffer move without tx-free request");
  AST_TX_IDLE_LEVEL: assert property (!tx_busy && $stable(serial_option_ctrl_r)
    |=> tx_line_r == !$past(serial_option_ctrl_r[OPT_TX_INV]))
    else $error("idle tx line level wrong for inversion setting");
  AST_IRQ_LEVEL: assert property (|(irq_stat_r & irq_mask_r) |->
    irq_r || $past(wr_stat || wr_mask))
    else $error("interrupt low while an unmasked flag is set");
endmodule : async_serial_port

/* File: tb/serial_peer.sv */
// remote serial transceiver model on the far side of the lines
`timescale 1ns/10ps
module serial_peer #(parameter int BIT = 4) (
  input wire logic clk_in,
  input wire logic inv_in,
  input wire logic line_in,
  output logic line_out
);
  logic line_r = 1'b1;
  realtime last_start;
  assign line_out = line_r ^ inv_in;
  function automatic logic pbit(input logic [7:0] v, input logic [1:0] m);
    return (m == 2'h3) ? ^v : ((m == 2'h2) ? ~^v : 1'b0);
  endfunction : pbit
  // start low, data, parity, stop (low if bad_stop), then one high bit
  task automatic send(input logic [7:0] d, input int n, input logic msb, input logic [1:0] par,
                      input logic bad_par, input logic bad_stop);
    logic q[$];
    q.push_back(1'b0);
    for (int i = 0; i < n; i++) q.push_back(msb ? d[n-1-i] : d[i]);
    if (par != 2'h0) q.push_back(pbit(n == 8 ? d : d & 8'h7F, par) ^ bad_par);
    q.push_back(~bad_stop);
    q.push_back(1'b1);
    foreach (q[i]) begin
      @(posedge clk_in);
      line_r <= q[i];
      repeat (BIT - 1) @(posedge clk_in);
    end
  endtask : send
  // centre sampling after a low start
  task automatic recv(input int n, input logic msb, input logic [1:0] par,
                      output logic [7:0] d, output logic p, output logic s);
    d = 8'h00;
    p = 1'b0;
    while ((line_in ^ inv_in) !== 1'b0) @(posedge clk_in);
    last_start = $realtime;
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk_in);
      d[msb ? n - 1 - i : i] = line_in ^ inv_in;
    end
    if (par != 2'h0) begin
      repeat (BIT) @(posedge clk_in);
      p = line_in ^ inv_in;
    end
    repeat (BIT) @(posedge clk_in);
    s = line_in ^ inv_in;
  endtask : recv
endmodule : serial_peer

/* File: tb/async_serial_port_tb.sv */
// self-checking bench of the asynchronous serial port
`timescale 1ns/10ps
module async_serial_port_tb;
  import serial_port_pkg::*;
  localparam int BIT = 4;
  logic mclk_in, rst_in, axi_awvalid_in, axi_wvalid_in, axi_bready_in, axi_arvalid_in;
  logic axi_rready_in, serial_rx_line_in, serial_tx_line_out, axi_awready_out, axi_wready_out;
  logic axi_bvalid_out, axi_arready_out, axi_rvalid_out, rx_error_irq_out, rx_done_irq_out;
  logic tx_free_irq_out, irq_out, inv, p, s;
  logic [31:0] axi_awaddr_in, axi_wdata_in, axi_araddr_in, axi_rdata_out, rv;
  logic [3:0] axi_wstrb_in;
  logic [1:0] axi_bresp_out, axi_rresp_out, rsp;
  logic [7:0] d;
  int mismatches, comparisons, cyc, n_done, n_free, n_err;
  async_serial_port async_serial_port_inst (.*);
  serial_peer #(.BIT(BIT)) serial_peer_inst (.clk_in(mclk_in), .inv_in(inv),
    .line_in(serial_tx_line_out), .line_out(serial_rx_line_in));
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    n_done += rx_done_irq_out;
    n_free += tx_free_irq_out;
    n_err += rx_error_irq_out;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    axi_awaddr_in <= {24'h0, a};
    axi_wdata_in <= {24'h0, v};
    axi_awvalid_in <= 1'b1;
    axi_wvalid_in <= 1'b1;
    axi_bready_in <= 1'b1;
    do @(posedge mclk_in); while (axi_awready_out !== 1'b1);
    axi_awvalid_in <= 1'b0;
    axi_wvalid_in <= 1'b0;
    do @(posedge mclk_in); while (axi_bvalid_out !== 1'b1);
    rsp = axi_bresp_out;
    axi_bready_in <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge mclk_in);
    axi_araddr_in <= {24'h0, a};
    axi_arvalid_in <= 1'b1;
    axi_rready_in <= 1'b1;
    do @(posedge mclk_in); while (axi_arready_out !== 1'b1);
    axi_arvalid_in <= 1'b0;
    do @(posedge mclk_in); while (axi_rvalid_out !== 1'b1);
    rv = axi_rdata_out;
    rsp = axi_rresp_out;
    axi_rready_in <= 1'b0;
  endtask : rd
  task wait_done(input int k);
    for (int j = 0; j < 40 && n_done < k; j++) @(posedge mclk_in);
  endtask : wait_done
  task t_regs;
    rd(ADDR_CTRL);
    check(rv, {24'h0, CTRL_RST});
    rd(8'h28);
    check(rsp, AXI_SLVERR);
    wr(8'h28, 8'h00);
    check(rsp, AXI_SLVERR);
    wr(ADDR_DIV, 8'h01);
    check(rsp, AXI_OKAY);
    rd(ADDR_DIV);
    check(rv, {24'h0, DIV_MIN});
    wr(ADDR_DIV, BIT[7:0]);
    $display("register test done");
  endtask : t_regs
  task t_modes;
    logic [7:0] modes [4] = '{8'h23, 8'h57, 8'h3B, 8'h4B};
    logic [7:0] c, m;
    realtime t0;
    int n, nb, dc;
    for (int i = 0; i < 4; i++) begin
      c = modes[i];
      n = c[CTRL_CHAR8] ? 8 : 7;
      m = c[CTRL_CHAR8] ? 8'hFF : 8'h7F;
      nb = 1 + n + (c[4:3] != 2'h0) + (c[CTRL_STOP2] ? 2 : 1);
      wr(ADDR_CTRL, c);
      n_free = 0;
      n_done = 0;
      fork
        begin
          wr(ADDR_TXD, 8'hD3);
          wr(ADDR_TXD, 8'h2C ^ i[7:0]);
        end
        begin
          serial_peer_inst.recv(n, c[CTRL_MSB], c[4:3], d, p, s);
          t0 = serial_peer_inst.last_start;
          check(d, 8'hD3 & m);
          check(p, serial_peer_inst.pbit(8'hD3 & m, c[4:3]));
          check(s, 1'b1);
          serial_peer_inst.recv(n, c[CTRL_MSB], c[4:3], d, p, s);
          dc = int'((serial_peer_inst.last_start - t0) / 100.0);
          check(d, (8'h2C ^ i[7:0]) & m);
          check(dc >= nb * BIT - 1 && dc <= nb * BIT + 1, 1'b1);
        end
      join
      check(n_free, 2);
      serial_peer_inst.send(8'hB5, n, c[CTRL_MSB], c[4:3], 1'b0, 1'b0);
      wait_done(1);
      check(n_done, 1);
      rd(ADDR_RXD);
      check(rv, {24'h0, 8'hB5 & m});
    end
    $display("mode test done");
  endtask : t_modes
  task t_errors;
    wr(ADDR_CTRL, 8'h3B);
    wr(ADDR_IRQ_MASK, 8'h07);
    wr(ADDR_IRQ_STAT, 8'h07);
    n_err = 0;
    n_done = 0;
    serial_peer_inst.send(8'h96, 8, 1'b0, 2'h3, 1'b1, 1'b0);
    wait_done(1);
    rd(ADDR_ERR);
    check(rv, 32'h1);
    rd(ADDR_RXD);
    serial_peer_inst.send(8'h5A, 8, 1'b0, 2'h3, 1'b0, 1'b1);
    wait_done(2);
    serial_peer_inst.send(8'h0F, 8, 1'b0, 2'h3, 1'b0, 1'b0);
    wait_done(3);
    rd(ADDR_ERR);
    check(rv, 32'h7);
    check(n_err, 3);
    check(irq_out, 1'b1);
    wr(ADDR_IRQ_MASK, 8'h00);
    check(irq_out, 1'b0);
    rd(ADDR_IRQ_STAT);
    check(rv, 32'h5);
    wr(ADDR_IRQ_STAT, 8'h05);
    wr(ADDR_ERR, 8'h07);
    rd(ADDR_ERR);
    check(rv, 32'h0);
    $display("error test done");
  endtask : t_errors
  task t_dis_inv;
    wr(ADDR_CTRL, 8'h21);
    n_done = 0;
    serial_peer_inst.send(8'h3E, 8, 1'b0, 2'h0, 1'b0, 1'b0);
    repeat (20) @(posedge mclk_in);
    check(n_done, 0);
    wr(ADDR_OPT, 8'h03);
    inv <= 1'b1;
    @(posedge mclk_in);
    check(serial_tx_line_out, 1'b0);
    wr(ADDR_CTRL, 8'h23);
    fork
      serial_peer_inst.send(8'h71, 8, 1'b0, 2'h0, 1'b0, 1'b0);
      wr(ADDR_TXD, 8'h4D);
      serial_peer_inst.recv(8, 1'b0, 2'h0, d, p, s);
    join
    check(d, 8'h4D);
    wait_done(1);
    rd(ADDR_RXD);
    check(rv, 32'h71);
    $display("duplex test done");
  endtask : t_dis_inv
  task close_out;
    $display("counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    rst_in = 1'b1;
    inv = 1'b0;
    {axi_awvalid_in, axi_wvalid_in, axi_bready_in, axi_arvalid_in, axi_rready_in} = 5'h00;
    {axi_awaddr_in, axi_wdata_in, axi_araddr_in} = 96'h0;
    axi_wstrb_in = 4'hF;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_regs();
    t_modes();
    t_errors();
    t_dis_inv();
    close_out();
  end
endmodule : async_serial_port_tb
